// ### mtfc_tx.sv
// transmit engine with flow control, its config registers and fifo
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mtfc_map.svh"

module mtfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  import mtfc_pkg::*;
  mtfc_fifo_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  always_comb begin
    push = in_valid_in && q.ready;
    pop = (q.count != 4'h0) && out_ready_in;
    d = q;
    if (push) begin
      d.wptr = (q.wptr == 3'(DEPTH - 1)) ? 3'h0 : q.wptr + 3'h1;
    end
    if (pop) begin
      d.rptr = (q.rptr == 3'(DEPTH - 1)) ? 3'h0 : q.rptr + 3'h1;
    end
    d.count = q.count + {3'h0, push} - {3'h0, pop};
    if (flush_in) begin
      d.wptr = 3'h0;
      d.rptr = 3'h0;
      d.count = 4'h0;
    end
    d.ready = d.count < 4'(DEPTH);
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[q.wptr] <= in_data_in;
    end
  end

  assign in_ready_out = q.ready;
  assign out_data_out = mem[q.rptr];
  assign out_valid_out = q.count != 4'h0;
endmodule

module mtfc_tx #(
  parameter bit host_interface_enable = 1'b1,
  parameter bit rx_pause_honour_default = 1'b1,
  parameter bit tx_pause_generate_default = 1'b1,
  parameter bit tx_reset_default = 1'b0,
  parameter bit tx_oversize_allow_default = 1'b0,
  parameter bit tx_client_fcs_default = 1'b0,
  parameter bit tx_enable_default = 1'b1,
  parameter bit tx_half_duplex_default = 1'b0,
  parameter logic [47:0] source_address = 48'h020000000001 // arbitrary
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [7:0] client_data_in,
  input wire logic client_last_in,
  input wire logic client_valid_in,
  output logic client_ready_out,
  input wire logic client_pause_request_in,
  input wire logic [15:0] client_pause_value_in,
  input wire logic rx_pause_frame_in,
  input wire logic [15:0] rx_pause_quanta_in,
  output logic rx_pause_forward_out,
  output logic [7:0] phy_txd_out,
  output logic phy_tx_en_out,
  output logic phy_tx_er_out
);
  import mtfc_pkg::*;

  localparam mtfc_cfg_t cfg_default = '{
    half: tx_half_duplex_default,
    enable: tx_enable_default,
    client_fcs: tx_client_fcs_default,
    oversize: tx_oversize_allow_default,
    treset: tx_reset_default,
    generate_en: tx_pause_generate_default,
    honour: rx_pause_honour_default
  };
  localparam logic [15:0] short_limit = `MTFC_MAX_FRAME - `MTFC_FCS_LEN;

  mtfc_regs_t q, d;
  logic pop;
  logic [8:0] fifo_data;
  logic fifo_valid;
  logic [15:0] limit;
  logic [31:0] crc_out;

  function automatic logic [31:0] crc_next(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MTFC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] pause_byte(input logic [15:0] n,
                                            input logic [15:0] value);
    logic [143:0] hdr;
    hdr = {`MTFC_PAUSE_DEST, source_address, `MTFC_PAUSE_TYPE,
           `MTFC_PAUSE_OPCODE, value};
    if (n < 16'd18) begin
      return hdr[8 * (17 - n) +: 8];
    end
    return 8'h00;
  endfunction

  function automatic mtfc_cfg_t word_to_cfg(input logic [31:0] w);
    mtfc_cfg_t c;
    c.honour = w[`MTFC_CFG_HONOUR_BIT];
    c.generate_en = w[`MTFC_CFG_GENERATE_BIT];
    c.treset = w[`MTFC_CFG_TRESET_BIT];
    c.oversize = w[`MTFC_CFG_OVERSIZE_BIT];
    c.client_fcs = w[`MTFC_CFG_CLIENT_FCS_BIT];
    c.enable = w[`MTFC_CFG_ENABLE_BIT];
    c.half = w[`MTFC_CFG_HALF_BIT];
    return c;
  endfunction

  mtfc_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .flush_in(q.cfg.treset),
    .in_data_in({client_last_in, client_data_in}),
    .in_valid_in(client_valid_in),
    .in_ready_out(client_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop)
  );

  always_comb begin
    d = q;
    pop = 1'b0;
    d.txen = 1'b0;
    d.txer = 1'b0;
    d.txd = 8'h00;
    d.fwd = 1'b0;
    d.rdata = 32'h0;
    crc_out = ~q.crc;
    limit = q.cfg.client_fcs ? `MTFC_MAX_FRAME : short_limit;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `MTFC_CFG_OFFSET: d.rdata = {25'h0, q.cfg};
        `MTFC_STATUS_OFFSET: begin
          d.rdata[`MTFC_STAT_PAUSE_LSB +: 16] = q.pause;
          d.rdata[`MTFC_STAT_PEND_BIT] = q.pend;
          d.rdata[`MTFC_STAT_INHIBIT_BIT] = q.pause != 16'h0;
          d.rdata[`MTFC_STAT_STATE_LSB +: 8] = q.st;
        end
        default: d.rdata = 32'h0;
      endcase
    end
    if (host_interface_enable && reg_wr_in &&
        reg_addr_in == `MTFC_CFG_OFFSET) begin
      d.cfg = word_to_cfg(reg_wdata_in);
    end
    if (d.cfg.treset) begin
      d.cfg = cfg_default;
      d.cfg.treset = 1'b1;
    end
    // pause quanta count down, one per 512 bit times
    if (q.pause != 16'h0) begin
      if (q.sub == `MTFC_QUANTUM_CYCLES) begin
        d.sub = 6'h0;
        d.pause = q.pause - 16'h1;
      end else begin
        d.sub = q.sub + 6'h1;
      end
    end
    if (rx_pause_frame_in) begin
      if (q.cfg.honour && !q.cfg.half) begin
        d.pause = rx_pause_quanta_in;
        d.sub = 6'h0;
      end else if (!q.cfg.honour) begin
        d.fwd = 1'b1;
      end
    end
    case (q.st)
      MTFC_IDLE: begin
        d.idx = 6'h0;
        if (q.cfg.enable && q.pause == 16'h0) begin
          if (q.pend) begin
            d.st = MTFC_PRE;
            d.psel = 1'b1;
            d.pend = 1'b0;
          end else if (fifo_valid) begin
            d.st = MTFC_PRE;
            d.psel = 1'b0;
          end
        end
      end
      MTFC_PRE: begin
        d.txen = 1'b1;
        d.txd = (q.idx == `MTFC_PREAMBLE_LEN) ? `MTFC_SFD_BYTE
                                              : `MTFC_PREAMBLE_BYTE;
        d.idx = q.idx + 6'h1;
        d.fcnt = 16'h0;
        d.crc = `MTFC_CRC_INIT;
        if (q.idx == `MTFC_PREAMBLE_LEN) begin
          d.st = q.psel ? MTFC_PSEND : MTFC_DATA;
        end
      end
      MTFC_DATA: begin
        d.txen = 1'b1;
        if (!fifo_valid ||
            (!q.cfg.oversize && q.fcnt >= limit)) begin
          d.txer = 1'b1;
          d.st = MTFC_DROP;
        end else begin
          pop = 1'b1;
          d.txd = fifo_data[7:0];
          d.crc = crc_next(q.crc, fifo_data[7:0]);
          d.fcnt = (q.fcnt == 16'hffff) ? q.fcnt : q.fcnt + 16'h1;
          d.idx = 6'h0;
          if (fifo_data[8]) begin
            if (q.cfg.client_fcs) begin
              d.st = MTFC_IFG;
            end else if (d.fcnt < `MTFC_MIN_FRAME) begin
              d.st = MTFC_PAD;
            end else begin
              d.st = MTFC_FCS;
            end
          end
        end
      end
      MTFC_DROP: begin
        pop = fifo_valid;
        d.idx = 6'h0;
        if (fifo_valid && fifo_data[8]) begin
          d.st = MTFC_IFG;
        end
      end
      MTFC_PAD, MTFC_PSEND: begin
        d.txen = 1'b1;
        d.txd = (q.st == MTFC_PSEND) ?
                pause_byte(q.fcnt, client_pause_value_in) : 8'h00;
        d.crc = crc_next(q.crc, d.txd);
        d.fcnt = q.fcnt + 16'h1;
        d.idx = 6'h0;
        if (d.fcnt == `MTFC_MIN_FRAME) begin
          d.st = MTFC_FCS;
        end
      end
      MTFC_FCS: begin
        d.txen = 1'b1;
        d.txd = crc_out[8 * q.idx[1:0] +: 8];
        d.idx = q.idx + 6'h1;
        if (q.idx == 6'h3) begin
          d.st = MTFC_IFG;
          d.idx = 6'h0;
        end
      end
      MTFC_IFG: begin
        d.idx = q.idx + 6'h1;
        if (q.idx == `MTFC_IFG_BYTES - 6'h1) begin
          d.st = MTFC_IDLE;
        end
      end
      default: d.st = MTFC_IDLE;
    endcase
    if (!q.cfg.generate_en || q.cfg.half) begin
      d.pend = 1'b0;
    end else if (client_pause_request_in) begin
      d.pend = 1'b1;
    end
    if (q.cfg.treset) begin
      d.st = MTFC_IDLE;
      d.pend = 1'b0;
      d.txen = 1'b0;
      d.txer = 1'b0;
      d.txd = 8'h00;
      pop = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.st <= MTFC_IDLE;
      q.cfg <= cfg_default;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign rx_pause_forward_out = q.fwd;
  assign phy_txd_out = q.txd;
  assign phy_tx_en_out = q.txen;
  assign phy_tx_er_out = q.txer;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  forward_pause_a: assert property (
    rx_pause_frame_in && !q.cfg.honour |=> rx_pause_forward_out)
    else $error("unhonoured pause frame not forwarded");
  pause_inhibit_a: assert property (
    q.pause != 16'h0 && q.st == MTFC_IDLE |=> q.st == MTFC_IDLE)
    else $error("transmitter not inhibited by pause frame");
  pause_request_a: assert property (
    client_pause_request_in && q.cfg.generate_en && !q.cfg.half &&
    !q.cfg.treset && q.st != MTFC_IDLE |=> q.pend)
    else $error("pause request not latched");
  pause_ignore_a: assert property (
    !q.cfg.generate_en |=> !q.pend ##1 q.st != MTFC_PSEND)
    else $error("pause frame sent while generation disabled");
  reset_hold_a: assert property (
    q.cfg.treset |=> q.st == MTFC_IDLE && !phy_tx_en_out)
    else $error("transmitter active during tx reset");
  reset_default_a: assert property (
    q.cfg.treset |-> q.cfg.enable == cfg_default.enable &&
    q.cfg.oversize == cfg_default.oversize &&
    q.cfg.client_fcs == cfg_default.client_fcs)
    else $error("settings not at default during tx reset");
  length_cap_a: assert property (
    !q.cfg.oversize && q.st == MTFC_DATA |-> q.fcnt <= `MTFC_MAX_FRAME)
    else $error("frame longer than legal maximum");
  pad_min_a: assert property (
    q.st == MTFC_FCS |-> q.fcnt >= `MTFC_MIN_FRAME)
    else $error("fcs appended before minimum length");
  enable_gate_a: assert property (
    q.st == MTFC_IDLE && !q.cfg.enable |=> q.st == MTFC_IDLE)
    else $error("frame started while transmitter disabled");
  fixed_cfg_a: assert property (
    !host_interface_enable |-> q.cfg == cfg_default)
    else $error("settings changed without host interface");
endmodule
`default_nettype wire

// ### mtfc_map.svh
// register offsets, field positions and timing counts of the tx block
`ifndef MTFC_MAP_SVH
`define MTFC_MAP_SVH

`define MTFC_CFG_OFFSET 8'h00
`define MTFC_STATUS_OFFSET 8'h04

`define MTFC_CFG_HONOUR_BIT 0
`define MTFC_CFG_GENERATE_BIT 1
`define MTFC_CFG_TRESET_BIT 2
`define MTFC_CFG_OVERSIZE_BIT 3
`define MTFC_CFG_CLIENT_FCS_BIT 4
`define MTFC_CFG_ENABLE_BIT 5
`define MTFC_CFG_HALF_BIT 6

`define MTFC_STAT_PAUSE_LSB 0
`define MTFC_STAT_PEND_BIT 16
`define MTFC_STAT_INHIBIT_BIT 17
`define MTFC_STAT_STATE_LSB 24

`define MTFC_PREAMBLE_LEN 6'd7
`define MTFC_PREAMBLE_BYTE 8'h55
`define MTFC_SFD_BYTE 8'hd5
`define MTFC_IFG_BYTES 6'd12
`define MTFC_MIN_FRAME 16'd60
`define MTFC_MAX_FRAME 16'd1518
`define MTFC_FCS_LEN 16'd4
`define MTFC_QUANTUM_BITS 512
`define MTFC_BITS_PER_CYCLE 8
`define MTFC_QUANTUM_CYCLES 6'((`MTFC_QUANTUM_BITS / `MTFC_BITS_PER_CYCLE) - 1)

`define MTFC_CRC_POLY 32'hedb88320
`define MTFC_CRC_INIT 32'hffffffff
`define MTFC_PAUSE_DEST 48'h0180c2000001
`define MTFC_PAUSE_TYPE 16'h8808
`define MTFC_PAUSE_OPCODE 16'h0001

`endif

// ### mtfc_pkg.sv
// types of the transmit and flow control block
`default_nettype none
package mtfc_pkg;

  typedef enum logic [7:0] {
    MTFC_IDLE = 8'h01,
    MTFC_PRE = 8'h02,
    MTFC_DATA = 8'h04,
    MTFC_DROP = 8'h08,
    MTFC_PAD = 8'h10,
    MTFC_PSEND = 8'h20,
    MTFC_FCS = 8'h40,
    MTFC_IFG = 8'h80
  } mtfc_state_t;

  typedef struct packed {
    logic half;
    logic enable;
    logic client_fcs;
    logic oversize;
    logic treset;
    logic generate_en;
    logic honour;
  } mtfc_cfg_t;

  typedef struct packed {
    mtfc_state_t st;
    mtfc_cfg_t cfg;
    logic psel;
    logic pend;
    logic [15:0] pause;
    logic [5:0] sub;
    logic [5:0] idx;
    logic [15:0] fcnt;
    logic [31:0] crc;
    logic [7:0] txd;
    logic txen;
    logic txer;
    logic fwd;
    logic [31:0] rdata;
  } mtfc_regs_t;

  typedef struct packed {
    logic [2:0] wptr;
    logic [2:0] rptr;
    logic [3:0] count;
    logic ready;
  } mtfc_fifo_t;

endpackage
`default_nettype wire

// ### mtfc_client_model.sv
// client model feeding frames and pause requests
`timescale 1ns/10ps
`default_nettype none
module mtfc_client_model (
  input wire logic sys_clk_in,
  input wire logic client_ready_in,
  output logic [7:0] data_out,
  output logic last_out,
  output logic valid_out,
  output logic pause_request_out,
  output logic [15:0] pause_value_out
);
  initial begin
    data_out = 8'h00;
    last_out = 1'b0;
    valid_out = 1'b0;
    pause_request_out = 1'b0;
    pause_value_out = 16'h0000;
  end

  // bytes i+1, last flagged; in client fcs mode the tail four are the fcs
  task automatic send_frame(input int n);
    for (int i = 0; i < n; i++) begin
      data_out <= 8'(i + 1);
      last_out <= (i == n - 1);
      valid_out <= 1'b1;
      @(posedge sys_clk_in);
      while (client_ready_in !== 1'b1) begin
        @(posedge sys_clk_in);
      end
    end
    valid_out <= 1'b0;
    last_out <= 1'b0;
    data_out <= ~data_out;
  endtask

  // one-cycle request, value held for the frame that follows
  task automatic pause_pulse(input logic [15:0] q);
    pause_value_out <= q;
    pause_request_out <= 1'b1;
    @(posedge sys_clk_in);
    pause_request_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### mtfc_tx_tb_top.sv
// self-checking testbench of the transmit and flow control block
`timescale 1ns/10ps
`default_nettype none
module mtfc_tx_tb_top;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rxp = 1'b0;
  logic [15:0] rxq = 16'h0;
  logic [31:0] rdata;
  logic [7:0] cd;
  logic [7:0] txd;
  logic [15:0] pval;
  logic cl, cv, cr, preq, fwd, tx_en, tx_er;
  logic [31:0] rdata_f;
  logic [31:0] fixed_rd = 32'h0;
  logic [7:0] txd_f;
  logic cr_f, fwd_f, tx_en_f, tx_er_f;
  logic [7:0] cap[$];
  logic [7:0] e[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int n_err = 0;
  int n_fwd = 0;
  int n_fixed_tx = 0;
  int n_fwd_f = 0;

  mtfc_tx u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .client_data_in(cd),
    .client_last_in(cl), .client_valid_in(cv), .client_ready_out(cr),
    .client_pause_request_in(preq), .client_pause_value_in(pval),
    .rx_pause_frame_in(rxp), .rx_pause_quanta_in(rxq),
    .rx_pause_forward_out(fwd), .phy_txd_out(txd), .phy_tx_en_out(tx_en),
    .phy_tx_er_out(tx_er));
  // second build: no host, every default bit flipped
  mtfc_tx #(.host_interface_enable(1'b0), .rx_pause_honour_default(1'b0),
    .tx_pause_generate_default(1'b0), .tx_reset_default(1'b1),
    .tx_oversize_allow_default(1'b1), .tx_client_fcs_default(1'b1),
    .tx_enable_default(1'b0), .tx_half_duplex_default(1'b1),
    .source_address(48'h020000000002)) u_fixed ( // arbitrary address
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata_f), .client_data_in(cd),
    .client_last_in(cl), .client_valid_in(cv), .client_ready_out(cr_f),
    .client_pause_request_in(preq), .client_pause_value_in(pval),
    .rx_pause_frame_in(rxp), .rx_pause_quanta_in(rxq),
    .rx_pause_forward_out(fwd_f), .phy_txd_out(txd_f),
    .phy_tx_en_out(tx_en_f), .phy_tx_er_out(tx_er_f));
  mtfc_client_model u_client (.sys_clk_in(sys_clk_in),
    .client_ready_in(cr), .data_out(cd), .last_out(cl), .valid_out(cv),
    .pause_request_out(preq), .pause_value_out(pval));

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // phy monitor
  always @(posedge sys_clk_in) begin
    if (tx_en === 1'b1) cap.push_back(txd);
    if (tx_er === 1'b1) n_err++;
    if (fwd === 1'b1) n_fwd++;
    if (tx_en_f === 1'b1 || tx_er_f === 1'b1) n_fixed_tx++;
    if (fwd_f === 1'b1) n_fwd_f++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    @(posedge sys_clk_in);
    d = rdata;
    fixed_rd = rdata_f;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic pause_in(input logic [15:0] q);
    rxq <= q;
    rxp <= 1'b1;
    @(posedge sys_clk_in);
    rxp <= 1'b0;
  endtask

  // waits for a whole frame on the phy, then checks its length
  task automatic expect_len(input int lim, input int n);
    int k;
    k = 0;
    while (tx_en !== 1'b1 && k < lim) begin
      @(posedge sys_clk_in);
      k++;
    end
    while (tx_en === 1'b1 && k < lim) begin
      @(posedge sys_clk_in);
      k++;
    end
    check(32'(k < lim), 32'h1);
    check(32'(cap.size()), 32'(n));
  endtask

  task automatic lim_case(input logic [31:0] c, input int n, input int l,
                          input int errs);
    int m;
    reg_wr(8'h00, c);
    cap.delete();
    m = n_err;
    u_client.send_frame(n);
    if (errs == 0) expect_len(4000, l);
    cycles(20);
    check(32'(n_err - m), 32'(errs));
  endtask

  function automatic logic [31:0] fcs_of(input int lo, input int hi);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = lo; i < hi; i++) begin
      c = c ^ {24'h0, e[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [31:0] v;
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd(8'h00, v);
    check(v, 32'h23);
    check(fixed_rd, 32'h5c);
    reg_rd(8'h08, v);
    check(v, 32'h0);
    $display("test defaults done");
    cap.delete();
    u_client.send_frame(3);
    expect_len(300, 72);
    repeat (7) e.push_back(8'h55);
    e.push_back(8'hd5);
    for (int i = 0; i < 60; i++) e.push_back(i < 3 ? 8'(i + 1) : 8'h00);
    v = fcs_of(8, 68);
    for (int i = 0; i < 4; i++) e.push_back(v[8*i +: 8]);
    for (int i = 0; i < 72; i++) check(32'(cap[i]), 32'(e[i]));
    $display("test pad and fcs done");
    cap.delete();
    u_client.pause_pulse(16'h0102);
    expect_len(300, 72);
    check({cap[8], cap[9], cap[20], cap[21]}, 32'h01808808);
    check(32'({cap[24], cap[25]}), 32'h0102);
    reg_wr(8'h00, 32'h21);
    cap.delete();
    u_client.pause_pulse(16'h0005);
    cycles(150);
    check(32'(cap.size()), 32'h0);
    $display("test pause send done");
    reg_wr(8'h00, 32'h22);
    pause_in(16'h0002);
    cycles(3);
    check(32'(n_fwd), 32'h1);
    reg_wr(8'h00, 32'h23);
    pause_in(16'h0002);
    reg_rd(8'h04, v);
    check(32'(v[17]), 32'h1);
    cap.delete();
    u_client.send_frame(3);
    cycles(90);
    check(32'(cap.size()), 32'h0);
    expect_len(300, 72);
    check(32'(n_fwd), 32'h1);
    reg_wr(8'h00, 32'h63);
    pause_in(16'h0002);
    u_client.pause_pulse(16'h0003);
    reg_rd(8'h04, v);
    check(32'(v[17:16]), 32'h0);
    check(32'(n_fwd), 32'h1);
    $display("test pause honour done");
    reg_wr(8'h00, 32'h03);
    cap.delete();
    u_client.send_frame(3);
    cycles(60);
    check(32'(cap.size()), 32'h0);
    reg_wr(8'h00, 32'h23);
    expect_len(300, 72);
    reg_wr(8'h00, 32'h3f);
    reg_rd(8'h00, v);
    check(v, 32'h27);
    check(fixed_rd, 32'h5c);
    cap.delete();
    u_client.send_frame(3);
    cycles(60);
    check(32'(cap.size()), 32'h0);
    reg_wr(8'h00, 32'h23);
    $display("test enable and reset done");
    cycles(1);
    reg_wr(8'h00, 32'h33);
    cap.delete();
    u_client.send_frame(64);
    expect_len(300, 72);
    check(32'(cap[71]), 32'h40);
    lim_case(32'h23, 1514, 1526, 0);
    lim_case(32'h23, 1515, 0, 1);
    lim_case(32'h2b, 1515, 1527, 0);
    $display("test fcs and length done");
    check(32'(n_fixed_tx), 32'h0);
    check(32'(n_fwd_f), 32'h3);
    $display("test fixed build done");
    complete_run();
  end
endmodule
`default_nettype wire
